// ---- inc/tgr_pkg.sv ----
////////////////////////////////////////////////////////////////////////////////
// Purpose: Constants for the timing generator control and status registers
// Assumes: Byte-wide register port, 100 MHz reference clock
// Notes:   Offsets are byte addresses on the register port
////////////////////////////////////////////////////////////////////////////////
package tgr_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_ACT_LO    = 8'h18;
  localparam logic [7:0] ADDR_ACT_HI    = 8'h19;
  localparam logic [7:0] ADDR_QUAL_LO   = 8'h1a;
  localparam logic [7:0] ADDR_QUAL_HI   = 8'h1b;
  localparam logic [7:0] ADDR_PRI_MODE  = 8'h1c;
  localparam logic [7:0] ADDR_PRI_BW    = 8'h1d;
  localparam logic [7:0] ADDR_PRI_AUTO  = 8'h1e;
  localparam logic [7:0] ADDR_PRI_MAN   = 8'h1f;
  localparam logic [7:0] ADDR_PRI_DEV   = 8'h20;
  localparam logic [7:0] ADDR_PRI_LONG  = 8'h24;
  localparam logic [7:0] ADDR_PRI_SHORT = 8'h28;
  localparam logic [7:0] ADDR_PRI_USER  = 8'h2c;
  localparam logic [7:0] ADDR_PRI_FILT  = 8'h30;
  localparam logic [7:0] ADDR_PRI_PRIO  = 8'h31;
  localparam logic [7:0] ADDR_PRI_STATE = 8'h37;
  localparam logic [7:0] ADDR_PRI_FLUSH = 8'h38;
  localparam logic [7:0] ADDR_SEC_MODE  = 8'h39;
  localparam logic [7:0] ADDR_SEC_BW    = 8'h3a;
  localparam logic [7:0] ADDR_SEC_AUTO  = 8'h3b;
  localparam logic [7:0] ADDR_SEC_MAN   = 8'h3c;

  // Group lengths in bytes
  localparam logic [2:0] LEN_FLAGS = 3'd2;
  localparam logic [2:0] LEN_HIST  = 3'd4;
  localparam logic [2:0] LEN_PRIO  = 3'd6;

  // Mode register fields
  localparam int MODE_ALIGN_BIT  = 0;
  localparam int MODE_HOSRC_BIT  = 2;
  localparam int MODE_REVERT_BIT = 3;
  localparam int MODE_AUTO_BIT   = 4;
  localparam int MODE_OOP_BIT    = 5;
  localparam logic [7:0] MODE_MASK = 8'h3d;
  localparam logic [7:0] MODE_RST  = 8'h00;

  // Bandwidth, selection, filter fields
  localparam logic [7:0] BW_MASK      = 8'h1f;
  localparam logic [4:0] BW_MAX_CODE  = 5'h0a;
  localparam logic [7:0] PRI_BW_RST   = 8'h06;
  localparam logic [7:0] SEC_BW_RST   = 8'h00;
  localparam logic [7:0] REF_MASK     = 8'h0f;
  localparam logic [7:0] MAN_RST      = 8'h00;
  localparam logic [3:0] SEL_FREERUN  = 4'h0;
  localparam logic [3:0] SEL_LAST_REF = 4'hc;
  localparam logic [3:0] SEL_HOLDOVER = 4'hd;
  localparam logic [7:0] FILT_MASK    = 8'h7f;
  localparam logic [7:0] FILT_RST     = 8'h27;
  localparam logic [2:0] LONG_MAX     = 3'h5;
  localparam int NUM_REFS     = 12;
  localparam int XSYNC_BIT    = 4;
  localparam int FLUSH_DEV_BIT = 0;

  // Lock state byte positions
  localparam int ST_SYNC  = 0;
  localparam int ST_LOS   = 1;
  localparam int ST_LOL   = 2;
  localparam int ST_OOP   = 3;
  localparam int ST_SAP   = 4;
  localparam int ST_TRACK = 6;
  localparam int ST_AVAIL = 7;

  // Multibyte access sequencer
  typedef enum logic [1:0]
  {
    SEQ_IDLE  = 2'b00,
    SEQ_READ  = 2'b01,
    SEQ_WRITE = 2'b10
  } tgr_seq_t;

endpackage

// ---- design/tgr_regs.sv ----
////////////////////////////////////////////////////////////////////////////////
// Purpose: Control and status registers of the two timing generators
// Assumes: Byte accesses arrive already decoded from the serial bus
// Notes:   Loop internals stay outside; their status enters as levels
//
// Function
// - Activity flags for refs 1-12 over two read-only bytes, 1 means active
// - Cross-couple input activity shown in bit 4 of second activity byte
// - Qualification flags in same layout as activity, 1 means qualified
// - Mode bit 0 selects phase align, bit 2 selects holdover source
// - Mode bit 3 selects revertive, bit 4 selects automatic selection
// - Manual mode, out of pull-in: follow if bit 5 clear, stop if set
// - Bandwidth codes 0-10 valid, 11-31 reserved, primary resets to 6
// - Auto reference code: 0 freerun, 1-12 ref, 13 holdover
// - Slave primary shows the master's active reference
// - Manual register drives selection: 0 freerun, 1-12 ref, 13 holdover
// - Read-only 32-bit device holdover history for the primary generator only
// - Read-only 32-bit long and short term histories
// - Writable user history, reset zero, used when source selects it
// - Long-term filter field bits 6-4, codes 6 and 7 reserved
// - Short-term filter field bits 3-2, four bandwidths
// - Ramp field bits 1-0, filter register resets to 0x27
// - Priority table of nibbles, odd ref low, lower value wins
// - Priority zero excludes a reference, all reset to zero
// - Lock state bits 0-4: sync, lost, unlocked, out of range, stopped
// - Bit 7 history available, bit 6 tracking, never 6 without 7
// - Flush write resets long history, bit 0 adds device history
// - Secondary has its own mode, bandwidth and reference registers
// - Reading the low byte latches the rest for consecutive reads
// - Ascending multibyte writes held, committed on most significant byte
// - Pull-in range equals disqualification range in 0.1 ppm steps
////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps

module tgr_regs
  import tgr_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  input  wire logic        i_wr_en,
  input  wire logic        i_rd_en,
  input  wire logic [7:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  output logic      [7:0]  o_rdata,
  output logic             o_rd_valid,
  input  wire logic [11:0] i_ref_active,
  input  wire logic        i_xsync_active,
  input  wire logic [11:0] i_ref_qualified,
  input  wire logic [9:0]  i_disq_range,
  input  wire logic [11:0] i_pri_offset,
  input  wire logic [11:0] i_sec_offset,
  input  wire logic        i_pri_is_slave,
  input  wire logic [3:0]  i_master_ref,
  input  wire logic [31:0] i_pri_dev_hist,
  input  wire logic [31:0] i_pri_long_hist,
  input  wire logic [31:0] i_pri_short_hist,
  input  wire logic [47:0] i_sec_priority,
  input  wire logic [1:0]  i_sync,
  input  wire logic [1:0]  i_sig_lost,
  input  wire logic [1:0]  i_lock_lost,
  input  wire logic [1:0]  i_hist_avail,
  input  wire logic [1:0]  i_hist_track,
  output logic      [3:0]  o_pri_active_ref,
  output logic      [3:0]  o_sec_active_ref,
  output logic      [1:0]  o_follow,
  output logic      [1:0]  o_phase_align,
  output logic      [4:0]  o_pri_loop_bw,
  output logic      [4:0]  o_sec_loop_bw,
  output logic      [1:0]  o_bw_valid,
  output logic      [31:0] o_pri_hold_value,
  output logic      [2:0]  o_long_filt,
  output logic             o_long_filt_valid,
  output logic      [1:0]  o_short_filt,
  output logic      [1:0]  o_ramp,
  output logic             o_flush_long,
  output logic             o_flush_device
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage
  logic [1:0][7:0]  mode;
  logic [1:0][7:0]  loop_bw;
  logic [1:0][7:0]  manual_ref;
  logic [1:0][3:0]  auto_sel;
  logic [1:0][3:0]  active_ref;
  logic [1:0][7:0]  pll_state;
  logic [1:0]       follow;
  logic [31:0]      user_hist;
  logic [7:0]       filt_ramp;
  logic [47:0]      prio_pri;
  logic [47:0]      rd_hold;
  logic [47:0]      wr_hold;
  logic [7:0]       seq_base;
  logic [2:0]       seq_idx;
  tgr_seq_t         seq_state;
  logic [7:0]       rdata;
  logic             rd_valid;
  logic             flush_long;
  logic             flush_dev;
  logic [31:0]      hold_value;

  ////////////////////////////////////////////////////////////////////////////
  // Multibyte group decode
  logic [7:0]  grp_base;
  logic [2:0]  grp_len;
  logic [47:0] grp_live;
  wire  [7:0]  grp_off  = i_addr - grp_base;
  wire  [2:0]  grp_idx  = grp_off[2:0];
  wire         grp_hit  = (grp_len != 3'd0);
  wire         is_base  = grp_hit && (grp_idx == 3'd0);
  wire         is_last  = grp_hit && (grp_idx == grp_len - 3'd1);
  wire         wr_grp   = (grp_base == ADDR_PRI_USER)
                       || (grp_base == ADDR_PRI_PRIO);
  wire         in_seq   = (seq_base == grp_base) && (seq_idx == grp_idx);
  wire         rd_go    = i_rd_en && !i_wr_en;
  wire         wr_go    = i_wr_en;

  always_comb
  begin
    grp_base = 8'h00;
    grp_len  = 3'd0;
    if (i_addr >= ADDR_ACT_LO && i_addr < ADDR_QUAL_LO)
    begin
      grp_base = ADDR_ACT_LO;
      grp_len  = LEN_FLAGS;
    end
    else if (i_addr >= ADDR_QUAL_LO && i_addr < ADDR_PRI_MODE)
    begin
      grp_base = ADDR_QUAL_LO;
      grp_len  = LEN_FLAGS;
    end
    else if (i_addr >= ADDR_PRI_DEV && i_addr < ADDR_PRI_FILT)
    begin
      grp_base = {i_addr[7:2], 2'b00};
      grp_len  = LEN_HIST;
    end
    else if (i_addr >= ADDR_PRI_PRIO && i_addr < ADDR_PRI_STATE)
    begin
      grp_base = ADDR_PRI_PRIO;
      grp_len  = LEN_PRIO;
    end
  end

  always_comb
  begin
    case (grp_base)
      ADDR_ACT_LO:
        grp_live = {32'h0, 3'b000, i_xsync_active, i_ref_active};
      ADDR_QUAL_LO:
        grp_live = {32'h0, 4'h0, i_ref_qualified};
      ADDR_PRI_DEV:   grp_live = {16'h0, i_pri_dev_hist};
      ADDR_PRI_LONG:  grp_live = {16'h0, i_pri_long_hist};
      ADDR_PRI_SHORT: grp_live = {16'h0, i_pri_short_hist};
      ADDR_PRI_USER:  grp_live = {16'h0, user_hist};
      ADDR_PRI_PRIO:  grp_live = prio_pri;
      default:        grp_live = 48'h0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path
  logic [7:0] rd_byte;

  always_comb
  begin
    case (i_addr)
      ADDR_PRI_MODE:  rd_byte = mode[0];
      ADDR_PRI_BW:    rd_byte = loop_bw[0];
      ADDR_PRI_AUTO:  rd_byte = {4'h0, auto_sel[0]};
      ADDR_PRI_MAN:   rd_byte = manual_ref[0];
      ADDR_PRI_FILT:  rd_byte = filt_ramp;
      ADDR_PRI_STATE: rd_byte = pll_state[0];
      ADDR_SEC_MODE:  rd_byte = mode[1];
      ADDR_SEC_BW:    rd_byte = loop_bw[1];
      ADDR_SEC_AUTO:  rd_byte = {4'h0, auto_sel[1]};
      ADDR_SEC_MAN:   rd_byte = manual_ref[1];
      default:
      begin
        if (!grp_hit)
          rd_byte = 8'h00;
        else if (!is_base && seq_state == SEQ_READ && in_seq)
          rd_byte = rd_hold[{grp_idx, 3'b000} +: 8];
        else
          rd_byte = grp_live[{grp_idx, 3'b000} +: 8];
      end
    endcase
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      rdata    <= 8'h00;
      rd_valid <= 1'b0;
    end
    else
    begin
      rd_valid <= rd_go;
      if (rd_go)
        rdata <= rd_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Multibyte sequencer
  logic [7:0] next_seq_base;
  logic [2:0] next_seq_idx;
  tgr_seq_t   next_seq_state;
  wire        rd_start = rd_go && is_base && !is_last;
  wire        rd_step  = rd_go && seq_state == SEQ_READ && in_seq && !is_base;
  wire        wr_start = wr_go && wr_grp && is_base;
  wire        wr_step  = wr_go && seq_state == SEQ_WRITE && in_seq
                      && !is_base;
  wire        wr_commit = wr_step && is_last;

  always_comb
  begin
    next_seq_base  = seq_base;
    next_seq_idx   = seq_idx + 3'd1;
    next_seq_state = seq_state;
    if (rd_start || wr_start)
    begin
      next_seq_base  = grp_base;
      next_seq_idx   = 3'd1;
      next_seq_state = rd_start ? SEQ_READ : SEQ_WRITE;
    end
    else if ((rd_step || wr_step) && !is_last)
      next_seq_state = seq_state;
    else if (rd_go || wr_go)
    begin
      // Any other access ends the burst
      next_seq_state = SEQ_IDLE;
      next_seq_idx   = 3'd0;
    end
    else
      next_seq_idx = seq_idx;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      seq_state <= SEQ_IDLE;
      seq_base  <= 8'h00;
      seq_idx   <= 3'd0;
      rd_hold   <= 48'h0;
      wr_hold   <= 48'h0;
    end
    else
    begin
      seq_state <= next_seq_state;
      seq_base  <= next_seq_base;
      seq_idx   <= next_seq_idx;
      if (rd_go && is_base)
        rd_hold <= grp_live;
      if (wr_start || wr_step)
        wr_hold[{grp_idx, 3'b000} +: 8] <= i_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Writable registers
  wire [47:0] wr_value = {i_wdata, 40'h0} | (wr_hold & ~{8'hff, 40'h0});
  wire [47:0] wr_full  = (grp_len == LEN_HIST)
                       ? {16'h0, i_wdata, wr_hold[23:0]} : wr_value;

  // read-only addresses have no write decode
  wire we_flush = wr_go && i_addr == ADDR_PRI_FLUSH;

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      mode       <= {MODE_RST, MODE_RST};
      loop_bw    <= {SEC_BW_RST, PRI_BW_RST};
      manual_ref <= {MAN_RST, MAN_RST};
      filt_ramp  <= FILT_RST;
      user_hist  <= 32'h0;
      prio_pri   <= 48'h0;
    end
    else if (wr_go)
    begin
      case (i_addr)
        ADDR_PRI_MODE: mode[0]       <= i_wdata & MODE_MASK;
        ADDR_SEC_MODE: mode[1]       <= i_wdata & MODE_MASK;
        ADDR_PRI_BW:   loop_bw[0]    <= i_wdata & BW_MASK;
        ADDR_SEC_BW:   loop_bw[1]    <= i_wdata & BW_MASK;
        ADDR_PRI_MAN:  manual_ref[0] <= i_wdata & REF_MASK;
        ADDR_SEC_MAN:  manual_ref[1] <= i_wdata & REF_MASK;
        ADDR_PRI_FILT: filt_ramp     <= i_wdata & FILT_MASK;
        default:
        begin
          if (wr_commit && grp_base == ADDR_PRI_USER)
            user_hist <= wr_full[31:0];
          if (wr_commit && grp_base == ADDR_PRI_PRIO)
            prio_pri <= wr_full;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      flush_long <= 1'b0;
      flush_dev  <= 1'b0;
    end
    else
    begin
      flush_long <= we_flush;
      flush_dev  <= we_flush && i_wdata[FLUSH_DEV_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-generator selection and status
  function automatic logic [3:0] best_ref(input logic [47:0] prio,
                                          input logic [11:0] qual);
    logic [3:0] best;
    logic [3:0] best_p;
    best   = SEL_FREERUN;
    best_p = 4'hf;
    for (int i = 0; i < NUM_REFS; i++)
    begin
      // Strict compare: ties go to the lower numbered reference
      if (qual[i] && prio[i*4 +: 4] != 4'h0
          && (best == SEL_FREERUN || prio[i*4 +: 4] < best_p))
      begin
        best   = 4'(i + 1);
        best_p = prio[i*4 +: 4];
      end
    end
    return best;
  endfunction

  wire [1:0][47:0] prio_tbl = {i_sec_priority, prio_pri};
  wire [1:0][11:0] offs     = {i_sec_offset, i_pri_offset};

  for (genvar g = 0; g < 2; g++)
  begin : gen_tg
    wire        is_auto  = mode[g][MODE_AUTO_BIT];
    wire [11:0] off      = offs[g];
    wire [11:0] off_mag  = off[11] ? (~off + 12'h001) : off;
    wire        out_of_pullin      = off_mag > {2'b00, i_disq_range};
    wire        stop     = !is_auto && out_of_pullin && mode[g][MODE_OOP_BIT];
    wire [3:0]  cur      = auto_sel[g];
    wire        cur_ref  = cur != SEL_FREERUN && cur <= SEL_LAST_REF;
    wire [3:0]  cur_m1   = cur - 4'h1;
    wire [5:0]  cur_pos  = {cur_m1, 2'b00};
    wire        cur_ok   = cur_ref && i_ref_qualified[cur_m1]
                        && prio_tbl[g][cur_pos +: 4] != 4'h0;
    wire [3:0]  cand     = best_ref(prio_tbl[g], i_ref_qualified);
    wire        slave    = (g == 0) && i_pri_is_slave;
    logic [3:0] next_auto;

    always_comb
    begin
      if (slave)
        next_auto = i_master_ref;
      else if (!mode[g][MODE_REVERT_BIT] && cur_ok)
        next_auto = cur;
      else if (cand != SEL_FREERUN)
        next_auto = cand;
      else if (i_hist_avail[g])
        next_auto = SEL_HOLDOVER;
      else
        next_auto = SEL_FREERUN;
    end

    always_ff @(posedge i_ref_clk)
    begin
      if (i_rst)
      begin
        auto_sel[g]   <= SEL_FREERUN;
        active_ref[g] <= SEL_FREERUN;
        follow[g]     <= 1'b1;
        pll_state[g]  <= 8'h00;
      end
      else
      begin
        auto_sel[g]   <= next_auto;
        active_ref[g] <= is_auto ? auto_sel[g] : manual_ref[g][3:0];
        follow[g]     <= !stop;
        pll_state[g]  <= {i_hist_avail[g],
                          i_hist_avail[g] && i_hist_track[g],
                          1'b0, stop, out_of_pullin, i_lock_lost[g],
                          i_sig_lost[g], i_sync[g]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs to the loop core
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      hold_value <= 32'h0;
    else
      hold_value <= mode[0][MODE_HOSRC_BIT] ? user_hist : i_pri_dev_hist;
  end

  assign o_bw_valid        = {loop_bw[1][4:0] <= BW_MAX_CODE,
                              loop_bw[0][4:0] <= BW_MAX_CODE};
  assign o_long_filt       = filt_ramp[6:4];
  assign o_long_filt_valid = filt_ramp[6:4] <= LONG_MAX;
  assign o_short_filt      = filt_ramp[3:2];
  assign o_ramp            = filt_ramp[1:0];
  assign o_pri_loop_bw     = loop_bw[0][4:0];
  assign o_sec_loop_bw     = loop_bw[1][4:0];
  assign o_phase_align     = {mode[1][MODE_ALIGN_BIT],
                              mode[0][MODE_ALIGN_BIT]};
  assign o_pri_active_ref  = active_ref[0];
  assign o_sec_active_ref  = active_ref[1];
  assign o_follow          = follow;
  assign o_pri_hold_value  = hold_value;
  assign o_flush_long      = flush_long;
  assign o_flush_device    = flush_dev;
  assign o_rdata           = rdata;
  assign o_rd_valid        = rd_valid;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);

  sequence s_rd(logic [7:0] a);
    i_rd_en && !i_wr_en && i_addr == a;
  endsequence

  AST_ACT_READ: assert property (
    s_rd(ADDR_ACT_LO) |=> o_rd_valid && o_rdata == $past(i_ref_active[7:0]))
    else $error("activity low byte wrong");

  AST_XSYNC_LATCH: assert property (
    s_rd(ADDR_ACT_LO) ##1 (!i_rd_en && !i_wr_en) [*2] ##1 s_rd(ADDR_ACT_HI)
      |=> o_rdata[XSYNC_BIT] == $past(i_xsync_active, 4))
    else $error("cross-couple bit not latched");

  AST_FLUSH: assert property (
    (i_wr_en && i_addr == ADDR_PRI_FLUSH)
      |=> o_flush_long && o_flush_device == $past(i_wdata[FLUSH_DEV_BIT])
      ##1 o_flush_long == $past(i_wr_en && i_addr == ADDR_PRI_FLUSH))
    else $error("flush strobe wrong");

  AST_NO_TRACK_ALONE: assert property (
    !pll_state[0][ST_AVAIL] |-> !pll_state[0][ST_TRACK])
    else $error("tracking without history");

  AST_SLAVE: assert property (
    i_pri_is_slave |=> auto_sel[0] == $past(i_master_ref))
    else $error("slave does not mirror master");

  AST_MANUAL: assert property (
    !mode[0][MODE_AUTO_BIT] && $stable(manual_ref[0])
      |=> o_pri_active_ref == $past(manual_ref[0][3:0]))
    else $error("manual selection not applied");

  AST_STOP: assert property (
    !mode[0][MODE_AUTO_BIT] && mode[0][MODE_OOP_BIT] && gen_tg[0].out_of_pullin
      |=> !o_follow[0] && pll_state[0][ST_SAP])
    else $error("out of pull-in still followed");

  AST_HOLD_SRC: assert property (
    mode[0][MODE_HOSRC_BIT] |=> o_pri_hold_value == $past(user_hist))
    else $error("user history not used");

  AST_PRIO_ZERO: assert property (
    !i_pri_is_slave && gen_tg[0].cand != SEL_FREERUN
      |-> prio_pri[{gen_tg[0].cand - 4'h1, 2'b00} +: 4] != 4'h0)
    else $error("disabled reference chosen");

endmodule

// ---- test/tgr_host.sv ----
// Purpose: Host model driving the byte register port
// Assumes: One access at a time, strobes move after rising edges
// Notes:   Multibyte groups start at the address given, which may be above the low byte
`timescale 1ns/1ps

module tgr_host
(
  input  wire logic       i_ref_clk,
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_rd_valid,
  output logic            o_wr_en,
  output logic            o_rd_en,
  output logic [7:0]      o_addr,
  output logic [7:0]      o_wdata
);
  initial
  begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr  = 8'h00;
    o_wdata = 8'h00;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    o_wr_en <= 1'b1;
    o_addr  <= a;
    o_wdata <= d;
    @(posedge i_ref_clk);
    o_wr_en <= 1'b0;
    o_wdata <= ~d;
  endtask

  // Missing valid pulse poisons the byte so compares fail
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_ref_clk);
    o_rd_en <= 1'b1;
    o_addr  <= a;
    @(posedge i_ref_clk);
    o_rd_en <= 1'b0;
    @(posedge i_ref_clk);
    d = (i_rd_valid === 1'b1) ? i_rdata : 8'hxx;
  endtask

  task automatic wr_n(input logic [7:0] a, input int n,
                      input logic [47:0] v);
    for (int i = 0; i < n; i++)
      wr(a + 8'(i), v[8*i +: 8]);
  endtask

  task automatic rd_n(input logic [7:0] a, input int n,
                      output logic [47:0] v);
    logic [7:0] b;
    v = '0;
    for (int i = 0; i < n; i++)
    begin
      rd(a + 8'(i), b);
      v[8*i +: 8] = b;
    end
  endtask
endmodule

// ---- test/timing_generator_ctrl_regs_tb.sv ----
// Purpose: Self-checking bench for the generator register block
// Assumes: Host model owns the byte port
// Notes:   Inputs move on rising edges by non-blocking assignment
`timescale 1ns/1ps

module timing_generator_ctrl_regs_tb;
  import tgr_pkg::*;
  logic        i_ref_clk, i_rst, i_wr_en, i_rd_en, i_xsync_active;
  logic        i_pri_is_slave, o_rd_valid, o_long_filt_valid;
  logic        o_flush_long, o_flush_device;
  logic [7:0]  i_addr, i_wdata, o_rdata, b;
  logic [9:0]  i_disq_range;
  logic [11:0] i_ref_active, i_ref_qualified, i_pri_offset, i_sec_offset;
  logic [3:0]  i_master_ref, o_pri_active_ref, o_sec_active_ref;
  logic [31:0] i_pri_dev_hist, i_pri_long_hist, i_pri_short_hist;
  logic [31:0] o_pri_hold_value, u;
  logic [47:0] i_sec_priority, v;
  logic [1:0]  i_sync, i_sig_lost, i_lock_lost, i_hist_avail, i_hist_track;
  logic [1:0]  o_follow, o_phase_align, o_bw_valid, o_short_filt, o_ramp;
  logic [4:0]  o_pri_loop_bw, o_sec_loop_bw;
  logic [2:0]  o_long_filt;
  integer      seed, num_errors, cmp_count;

  tgr_regs dut (.*);
  tgr_host host (.i_ref_clk(i_ref_clk), .i_rdata(o_rdata),
    .i_rd_valid(o_rd_valid), .o_wr_en(i_wr_en), .o_rd_en(i_rd_en),
    .o_addr(i_addr), .o_wdata(i_wdata));

  initial
  begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end

  task automatic chk(input logic [47:0] g, input logic [47:0] e);
    cmp_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk_rd(input logic [47:0] g, input logic [47:0] e);
    chk(g, e);
  endtask

  task automatic chk_out(input logic [47:0] g, input logic [47:0] e);
    chk(g, e);
  endtask

  function automatic logic bw_ok(input logic [4:0] c);
    return c <= 5'd10;
  endfunction

  function automatic logic [7:0] st_exp();
    return {i_hist_avail[0], i_hist_avail[0] & i_hist_track[0], 3'b000,
            i_lock_lost[0], i_sig_lost[0], i_sync[0]};
  endfunction

  task automatic settle(input int n);
    repeat (n) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
  endtask

  // Primary offset stays well inside the 100 pull-in range; secondary offset is unconstrained
  task automatic rnd_in();
    @(posedge i_ref_clk);
    i_ref_active     <= 12'($random(seed));
    i_ref_qualified  <= 12'($random(seed));
    i_xsync_active   <= 1'($random(seed));
    i_pri_dev_hist   <= $random(seed);
    i_pri_long_hist  <= $random(seed);
    i_pri_short_hist <= $random(seed);
    i_sec_priority   <= 48'($random(seed));
    i_sec_offset     <= 12'($random(seed));
    i_pri_offset     <= 12'($random(seed) % 50);
    i_disq_range     <= 10'd100;
    i_master_ref     <= 4'($random(seed));
    {i_sync, i_sig_lost, i_lock_lost, i_hist_avail, i_hist_track}
      <= 10'($random(seed));
    @(posedge i_ref_clk);
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    #100000;
    num_errors++;
    finish_test();
  end

  initial
  begin
    seed = 57;
    num_errors = 0;
    cmp_count = 0;
    i_rst = 1'b1;
    {i_ref_active, i_ref_qualified, i_xsync_active, i_pri_is_slave} = '0;
    {i_pri_dev_hist, i_pri_long_hist, i_pri_short_hist, i_master_ref} = '0;
    {i_sec_priority, i_sec_offset, i_pri_offset, i_disq_range} = '0;
    {i_sync, i_sig_lost, i_lock_lost, i_hist_avail, i_hist_track} = '0;
    repeat (16) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    host.rd(ADDR_PRI_BW, b);
    chk_rd(b, PRI_BW_RST);
    host.rd(ADDR_SEC_BW, b);
    chk_rd(b, SEC_BW_RST);
    host.rd(ADDR_PRI_FILT, b);
    chk_rd(b, 8'h27);
    host.rd_n(ADDR_PRI_PRIO, 6, v);
    chk_rd(v, 48'h0);
    $display("reset test end");
    repeat (4)
    begin
      rnd_in();
      host.rd_n(ADDR_ACT_LO, 2, v);
      chk_rd(v, {i_xsync_active, i_ref_active});
      host.wr(ADDR_ACT_LO, 8'hff);
      host.rd_n(ADDR_QUAL_LO, 2, v);
      chk_rd(v, i_ref_qualified);
      host.rd(ADDR_ACT_LO, b);
      chk_rd(b, i_ref_active[7:0]);
      host.rd(8'h70, b);
      chk_rd(b, 8'h00);
      host.rd(ADDR_PRI_STATE, b);
      chk_rd(b & 8'hc7, st_exp());
    end
    host.rd(ADDR_PRI_DEV, b);
    u = i_pri_dev_hist;
    i_pri_dev_hist <= ~u;
    host.rd_n(ADDR_PRI_DEV + 8'd1, 3, v);
    chk_rd({v[23:0], b}, u);
    host.rd_n(ADDR_PRI_LONG, 4, v);
    chk_rd(v, i_pri_long_hist);
    host.rd_n(ADDR_PRI_SHORT, 4, v);
    chk_rd(v, i_pri_short_hist);
    $display("flag test end");
    host.wr(ADDR_PRI_MODE, 8'h04);
    u = $random(seed);
    host.wr_n(ADDR_PRI_USER, 4, u);
    settle(2);
    chk_out(o_pri_hold_value, u);
    host.wr(ADDR_PRI_USER + 8'd3, 8'h5a);
    host.rd_n(ADDR_PRI_USER, 4, v);
    chk_rd(v, u);
    host.wr(ADDR_PRI_MODE, 8'h00);
    settle(2);
    chk_out(o_pri_hold_value, i_pri_dev_hist);
    for (int i = 0; i < 4; i++)
    begin
      b = 8'($random(seed));
      host.wr(ADDR_PRI_MODE, b);
      host.wr(ADDR_SEC_MODE, ~b);
      host.rd(ADDR_PRI_MODE, v[7:0]);
      chk_rd(v[7:0], b & MODE_MASK);
      host.rd(ADDR_SEC_MODE, v[7:0]);
      chk_rd(v[7:0], ~b & MODE_MASK);
      chk_out(o_phase_align, {~b[0], b[0]});
    end
    for (int c = 0; c < 32; c++)
    begin
      host.wr(ADDR_PRI_BW, 8'(c));
      host.wr(ADDR_SEC_BW, 8'(31 - c));
      settle(0);
      chk_out({o_pri_loop_bw, o_sec_loop_bw, o_bw_valid}, {5'(c),
        5'(31 - c), bw_ok(5'(31 - c)), bw_ok(5'(c))});
    end
    for (int i = 0; i < 8; i++)
    begin
      b = {1'b0, 3'(i), 4'($random(seed))};
      host.wr(ADDR_PRI_FILT, b | 8'h80);
      settle(0);
      chk_out({o_long_filt_valid, o_long_filt, o_short_filt, o_ramp},
        {i < 6, b[6:0]});
      host.rd(ADDR_PRI_FILT, v[7:0]);
      chk_rd(v[7:0], b);
    end
    $display("control test end");
    host.wr(ADDR_PRI_MODE, 8'h00);
    host.wr(ADDR_SEC_MODE, 8'h00);
    for (int r = 0; r < 14; r++)
    begin
      host.wr(ADDR_PRI_MAN, 8'(r));
      host.wr(ADDR_SEC_MAN, 8'(13 - r));
      settle(2);
      chk_out({o_pri_active_ref, o_sec_active_ref},
        {4'(r), 4'(13 - r)});
    end
    host.wr(ADDR_PRI_MAN, 8'd1);
    host.wr(ADDR_PRI_MODE, 8'h20);
    for (int i = 0; i < 3; i++)
    begin
      if (i == 2)
        host.wr(ADDR_PRI_MODE, 8'h00);
      @(posedge i_ref_clk);
      i_pri_offset <= (i == 1) ? 12'd99 : 12'd101;
      settle(3);
      chk_out(o_follow[0], i > 0);
    end
    @(posedge i_ref_clk);
    i_ref_qualified <= 12'hfff;
    host.wr(ADDR_PRI_MODE, 8'h18);
    host.wr_n(ADDR_PRI_PRIO, 6, 48'h0001_0002_0000);
    host.rd_n(ADDR_PRI_PRIO, 6, v);
    chk_rd(v, 48'h0001_0002_0000);
    settle(3);
    host.rd(ADDR_PRI_AUTO, b);
    chk_rd(b, 8'd9);
    host.wr_n(ADDR_PRI_PRIO, 6, 48'h0000_0002_0000);
    settle(3);
    host.rd(ADDR_PRI_AUTO, b);
    chk_rd(b, 8'd5);
    i_pri_is_slave <= 1'b1;
    i_master_ref <= 4'd7;
    settle(3);
    host.rd(ADDR_PRI_AUTO, b);
    chk_rd(b, 8'd7);
    $display("select test end");
    for (int d = 0; d < 2; d++)
    begin
      host.wr(ADDR_PRI_FLUSH, 8'(d));
      settle(0);
      chk_out({o_flush_long, o_flush_device}, {1'b1, 1'(d)});
      settle(0);
      chk_out({o_flush_long, o_flush_device}, 2'b00);
    end
    $display("flush test end");
    finish_test();
  end
endmodule
